// ### hw/quasi_bidir_parallel_ports.sv
// four 8-bit parallel ports with edge flags, port b input latch and alternate pin duties
`timescale 1ns/1ps
// Function
// RULE_01: thirty-two lines as four 8-bit ports; first three ports are per-bit direction.
// RULE_02: fourth port is all inputs when mode bit 5 is 0, all outputs when 1.
// RULE_03: port writes never disturb a first or third port pin on alternate duty.
// RULE_04: port data registers sit at page-zero addresses 0000 to 0003, no direction registers.
// RULE_05: first three ports: register bit 1 makes the line an input via pull-up.
// RULE_06: chip reset sets every bit of all four port registers to 1.
// RULE_07: ordinary read returns sampled pin levels, not the written register.
// RULE_08: read phase of read-modify-write returns the port register contents.
// RULE_09: an output line drives high for register bit 1 and low for 0.
// RULE_10: first port pins select plain io, serial, counter or latch strobe by control regs.
// RULE_11: first port pins 0,1 detect rising edges; pins 2,3 detect falling edges.
// RULE_12: edges set flag bits; interrupt request only where the enable bit is set.
// RULE_13: edges resolve at half the clock rate; sources must not toggle faster.
// RULE_14: mode bit 4 makes first port pin 0 the strobe latching second port input.
// RULE_15: edge flags stay set until a bit-clear instruction or chip reset.
// RULE_16: pins are synchronised before edge comparison so each edge flags once.
module quasi_bidir_parallel_ports (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire quasi_ports_pkg::bus_req_t bus_req,
  output logic [7:0] bus_rd_data,
  input wire logic [7:0] mode_control_reg,
  input wire logic [7:0] serial_control_reg,
  input wire logic full_addr_mode,
  input wire quasi_ports_pkg::alt_out_t alt_out,
  input wire logic [3:0] irq_enable,
  input wire logic [3:0] bit_clear_instr,
  input wire logic [7:0] first_port_pins_in,
  input wire logic [7:0] second_port_pins_in,
  input wire logic [7:0] third_port_pins_in,
  input wire logic [7:0] fourth_port_pins_in,
  output quasi_ports_pkg::pin_drive_t first_port_pins,
  output quasi_ports_pkg::pin_drive_t second_port_pins,
  output quasi_ports_pkg::pin_drive_t third_port_pins,
  output quasi_ports_pkg::pin_drive_t fourth_port_pins,
  output logic [3:0] irq_flag_reg,
  output logic irq_req
);
  import quasi_ports_pkg::*;

  logic [PORT_COUNT-1:0][PORT_WIDTH-1:0] port_q, port_d;
  logic [7:0] rd_q, rd_d;
  logic [EDGE_LINES-1:0] flag_q, flag_d;
  logic irq_q, irq_d;
  logic [3:0] sync1_q, sync2_q, sync3_q;
  logic [3:0] sync1_d, sync2_d, sync3_d;
  logic [7:0] latch_q, latch_d;
  pin_drive_t first_drv_q, first_drv_d, second_drv_q, second_drv_d;
  pin_drive_t third_drv_q, third_drv_d, fourth_drv_q, fourth_drv_d;
  logic hit;
  logic [1:0] idx;
  logic [3:0] edge_seen;
  logic strobe_rise;

  // page zero decode: only the four lowest addresses belong to the ports
  assign hit = (bus_req.addr[15:2] == ADDR_PORT_A[15:2]); // [RULE_04]
  assign idx = bus_req.addr[1:0];

  // edges compare the second and third stages; the first stage only feeds the second
  assign edge_seen = {~sync2_q[3] & sync3_q[3], ~sync2_q[2] & sync3_q[2],
                      sync2_q[1] & ~sync3_q[1], sync2_q[0] & ~sync3_q[0]}; // [RULE_11]
  assign strobe_rise = edge_seen[PIN_STROBE];

  // synchroniser and edge history, one new sample per clock bounds edge rate to half
  always_comb begin
    sync1_d = first_port_pins_in[3:0]; // [RULE_16] [RULE_13]
    sync2_d = sync1_q;
    sync3_d = sync2_q;
  end

  // port registers, read data, flags and latch
  always_comb begin
    port_d = port_q;
    rd_d = rd_q;
    latch_d = latch_q;
    // set wins over a clear arriving in the same cycle
    flag_d = (flag_q & ~bit_clear_instr) | edge_seen; // [RULE_12] [RULE_15]
    irq_d = |(flag_q & irq_enable); // [RULE_12]
    if (mode_control_reg[MODE_LATCH] && strobe_rise) begin
      latch_d = second_port_pins_in; // [RULE_14]
    end
    if (hit && bus_req.wr) begin
      port_d[idx] = bus_req.wdata; // [RULE_01] [RULE_04]
    end
    if (hit && bus_req.rd) begin
      if (bus_req.rmw_rd) begin
        rd_d = port_q[idx]; // [RULE_08]
      end else begin
        unique case (idx)
          2'd0: rd_d = first_port_pins_in; // [RULE_07]
          2'd1: rd_d = mode_control_reg[MODE_LATCH] ? latch_q : second_port_pins_in;
          2'd2: rd_d = third_port_pins_in;
          2'd3: rd_d = fourth_port_pins_in;
        endcase
      end
    end
  end

  // pin drive: quasi ports pull low hard and leave a 1 to the pull-up
  always_comb begin
    first_drv_d.out = port_q[0]; // [RULE_09]
    first_drv_d.oe_n = port_q[0]; // [RULE_05]
    second_drv_d.out = port_q[1];
    second_drv_d.oe_n = mode_control_reg[MODE_LATCH] ? 8'hFF : port_q[1];
    third_drv_d.out = port_q[2];
    third_drv_d.oe_n = port_q[2];
    fourth_drv_d.out = port_q[3];
    fourth_drv_d.oe_n = {8{~mode_control_reg[MODE_FOURTH_DRIVE]}}; // [RULE_02]
    // alternate duties override the register so port writes cannot disturb them
    if (mode_control_reg[MODE_LATCH]) begin
      first_drv_d.oe_n[PIN_STROBE] = 1'b1; // [RULE_10] [RULE_14]
    end
    if (mode_control_reg[MODE_CNT_A_IN] || serial_control_reg[SER_RCVR]) begin
      first_drv_d.oe_n[PIN_CNT_A] = 1'b1; // [RULE_03]
    end else if (serial_control_reg[SER_XMTR] && serial_control_reg[SER_SHIFT_CLK]) begin
      first_drv_d.out[PIN_CNT_A] = alt_out.ser_clk; // [RULE_10]
      first_drv_d.oe_n[PIN_CNT_A] = 1'b0;
    end else if (mode_control_reg[MODE_CNT_A_OUT]) begin
      first_drv_d.out[PIN_CNT_A] = alt_out.cnt_a; // [RULE_03]
      first_drv_d.oe_n[PIN_CNT_A] = 1'b0;
    end
    if (mode_control_reg[MODE_CNT_B_IN]) begin
      first_drv_d.oe_n[PIN_CNT_B] = 1'b1;
    end else if (mode_control_reg[MODE_CNT_B_OUT]) begin
      first_drv_d.out[PIN_CNT_B] = alt_out.cnt_b;
      first_drv_d.oe_n[PIN_CNT_B] = 1'b0;
    end
    if (serial_control_reg[SER_XMTR]) begin
      first_drv_d.out[PIN_XMTR] = alt_out.xmtr;
      first_drv_d.oe_n[PIN_XMTR] = 1'b0;
    end
    if (serial_control_reg[SER_RCVR]) begin
      first_drv_d.oe_n[PIN_RCVR] = 1'b1;
    end
    if (full_addr_mode) begin
      third_drv_d.out[PIN_A13] = alt_out.addr13; // [RULE_03]
      third_drv_d.out[PIN_A14] = alt_out.addr14;
      third_drv_d.oe_n[PIN_A13] = 1'b0;
      third_drv_d.oe_n[PIN_A14] = 1'b0;
    end
  end

  // register stage; reset leaves every line an input
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      port_q <= {PORT_COUNT{PORT_RESET}}; // [RULE_06]
      rd_q <= 8'h00;
      flag_q <= 4'h0; // [RULE_15]
      irq_q <= 1'b0;
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      sync3_q <= 4'hF;
      latch_q <= 8'h00;
      first_drv_q <= {PORT_RESET, PORT_RESET};
      second_drv_q <= {PORT_RESET, PORT_RESET};
      third_drv_q <= {PORT_RESET, PORT_RESET};
      fourth_drv_q <= {PORT_RESET, PORT_RESET};
    end else begin
      port_q <= port_d;
      rd_q <= rd_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
      latch_q <= latch_d;
      first_drv_q <= first_drv_d;
      second_drv_q <= second_drv_d;
      third_drv_q <= third_drv_d;
      fourth_drv_q <= fourth_drv_d;
    end
  end

  assign bus_rd_data = rd_q;
  assign irq_flag_reg = flag_q;
  assign irq_req = irq_q;
  assign first_port_pins = first_drv_q;
  assign second_port_pins = second_drv_q;
  assign third_port_pins = third_drv_q;
  assign fourth_port_pins = fourth_drv_q;

  // checks
  sequence rise_on_pin0;
    !sync2_q[0] ##1 sync2_q[0];
  endsequence

  sequence fall_on_pin2;
    sync2_q[2] ##1 !sync2_q[2];
  endsequence

  a_reset_ones: assert property (@(posedge ref_clk) // [RULE_06]
    !nrst |=> (port_q == {PORT_COUNT{PORT_RESET}}) && (first_port_pins.oe_n == 8'hFF))
    else $error("port registers not all ones after reset");

  a_fourth_dir: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_02]
    $past(nrst)
    |-> fourth_port_pins.oe_n == {8{~$past(mode_control_reg[MODE_FOURTH_DRIVE])}})
    else $error("fourth port direction does not follow mode bit 5");

  a_quasi_drive: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_09]
    ##1 (third_port_pins.out[5:0] == $past(port_q[2][5:0]))
       && (third_port_pins.oe_n[5:0] == $past(port_q[2][5:0])))
    else $error("third port pin drive does not follow register");

  a_decode_write: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_04]
    (bus_req.wr && bus_req.addr == ADDR_PORT_B) |=> port_q[1] == $past(bus_req.wdata))
    else $error("write to second port address not stored");

  a_read_pins: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_07]
    (bus_req.rd && !bus_req.rmw_rd && bus_req.addr == ADDR_PORT_C)
    |=> bus_rd_data == $past(third_port_pins_in))
    else $error("ordinary read did not return pin levels");

  a_rmw_read: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_08]
    (bus_req.rd && bus_req.rmw_rd && bus_req.addr == ADDR_PORT_A)
    |=> bus_rd_data == $past(port_q[0]))
    else $error("read-modify-write read did not return register");

  a_rise_flag: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_11]
    rise_on_pin0 |=> flag_q[0])
    else $error("rising edge on pin 0 did not set flag");

  a_fall_flag: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_11]
    fall_on_pin2 |=> flag_q[2])
    else $error("falling edge on pin 2 did not set flag");

  a_flag_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_15]
    (flag_q[1] && !bit_clear_instr[1]) |=> flag_q[1])
    else $error("edge flag dropped without a clear");

  a_irq_gate: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_12]
    ##1 irq_req == $past(|(flag_q & irq_enable)))
    else $error("interrupt request not gated by enables");

  a_alt_protect: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_03]
    (full_addr_mode && bus_req.wr) |=> third_port_pins.out[PIN_A13] == $past(alt_out.addr13))
    else $error("port write disturbed an address pin");
endmodule

// ### include/quasi_ports_pkg.sv
// constants and carrier types for the four quasi-bidirectional parallel ports
package quasi_ports_pkg;
  // port data registers in page zero
  localparam logic [15:0] ADDR_PORT_A = 16'h0000;
  localparam logic [15:0] ADDR_PORT_B = 16'h0001;
  localparam logic [15:0] ADDR_PORT_C = 16'h0002;
  localparam logic [15:0] ADDR_PORT_D = 16'h0003;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam int PORT_COUNT = 4;
  localparam int PORT_WIDTH = 8;
  localparam int EDGE_LINES = 4;
  // mode control bit positions
  localparam int MODE_CNT_A_OUT = 0;
  localparam int MODE_CNT_A_IN = 1;
  localparam int MODE_CNT_B_OUT = 2;
  localparam int MODE_CNT_B_IN = 3;
  localparam int MODE_LATCH = 4;
  localparam int MODE_FOURTH_DRIVE = 5;
  // serial control bit positions
  localparam int SER_SHIFT_CLK = 5;
  localparam int SER_RCVR = 6;
  localparam int SER_XMTR = 7;
  // first port pins with alternate duties
  localparam int PIN_STROBE = 0;
  localparam int PIN_CNT_A = 4;
  localparam int PIN_CNT_B = 5;
  localparam int PIN_XMTR = 6;
  localparam int PIN_RCVR = 7;
  // third port pins carrying high address bits
  localparam int PIN_A13 = 6;
  localparam int PIN_A14 = 7;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic rmw_rd;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } pin_drive_t;

  typedef struct packed {
    logic cnt_a;
    logic cnt_b;
    logic ser_clk;
    logic xmtr;
    logic addr13;
    logic addr14;
  } alt_out_t;
endpackage

// ### test/port_board_model.sv
// board model: pull-ups on the quasi ports, external drivers, floating fourth port
`timescale 1ns/1ps
module port_board_model (
  input wire logic ref_clk,
  input wire quasi_ports_pkg::pin_drive_t [3:0] drv,
  input wire logic [3:0][7:0] ext_val,
  input wire logic [3:0][7:0] ext_en,
  output logic [3:0][7:0] lvl
);
  import quasi_ports_pkg::*;
  logic [7:0] last_d_q = 8'h00; // known start so a floating line never reads unknown
  // resolve every wire; an undriven fourth port wobbles since it has no pull-up
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (!drv[p].oe_n[b]) lvl[p][b] = drv[p].out[b];
        else if (ext_en[p][b]) lvl[p][b] = ext_val[p][b];
        else if (p < 3) lvl[p][b] = 1'b1;
        else lvl[p][b] = ~last_d_q[b];
      end
    end
  end
  // remember the last fourth port level so a floating line never holds still
  always_ff @(posedge ref_clk) begin
    last_d_q <= lvl[3];
  end
endmodule

// ### test/quasi_bidir_parallel_ports_tb.sv
// self-checking bench for the four quasi-bidirectional parallel ports
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module quasi_bidir_parallel_ports_tb;
  import quasi_ports_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  bus_req_t req = '0;
  logic [7:0] rd_data, mode_ctl = 8'h00, ser_ctl = 8'h00;
  logic full_addr = 1'b0;
  alt_out_t alt = '0;
  logic [3:0] irq_en = 4'h0, clr = 4'h0, flags;
  logic irq;
  logic [3:0][7:0] ext_val = '0, ext_en = '0, lvl;
  wire pin_drive_t [3:0] drv;
  int errors = 0, n_tests = 0, cyc = 0;

  quasi_bidir_parallel_ports i_quasi_bidir_parallel_ports (.ref_clk(ref_clk), .nrst(nrst),
    .bus_req(req), .bus_rd_data(rd_data), .mode_control_reg(mode_ctl),
    .serial_control_reg(ser_ctl), .full_addr_mode(full_addr), .alt_out(alt),
    .irq_enable(irq_en), .bit_clear_instr(clr), .first_port_pins_in(lvl[0]),
    .second_port_pins_in(lvl[1]), .third_port_pins_in(lvl[2]),
    .fourth_port_pins_in(lvl[3]), .first_port_pins(drv[0]), .second_port_pins(drv[1]),
    .third_port_pins(drv[2]), .fourth_port_pins(drv[3]), .irq_flag_reg(flags),
    .irq_req(irq));
  port_board_model i_port_board_model (.ref_clk(ref_clk), .drv(drv), .ext_val(ext_val),
    .ext_en(ext_en), .lvl(lvl));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      test_done();
    end
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // answer lands one edge after the request edge and holds; taken at the edge after
  task automatic rd(input logic [15:0] a, input logic rmw, output logic [7:0] d);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    req.rmw_rd <= rmw;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    req.rmw_rd <= 1'b0;
    @(posedge ref_clk);
    d = rd_data;
  endtask

  // pull one pin low for a few cycles, keeping edges well apart
  task automatic pulse_low(input int p, input int b);
    @(posedge ref_clk);
    ext_en[p][b] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ext_en[p][b] <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  initial begin
    logic [7:0] d;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int p = 0; p < 4; p++) `CHK(drv[p], 16'hFFFF, "pin drive after reset")
    `CHK(flags, 4'h0, "flags after reset")
    rd(ADDR_PORT_B, 1'b1, d);
    `CHK(d, PORT_RESET, "register after reset")
    // per-bit direction on the first port: zeros drive low, ones released
    wr(ADDR_PORT_A, 8'hAF);
    `CHK(drv[0].oe_n, 8'hAF, "first port direction")
    ext_en[0][5] <= 1'b1;
    rd(ADDR_PORT_A, 1'b0, d);
    `CHK(d, 8'h8F, "plain read gives pins")
    rd(ADDR_PORT_A, 1'b1, d);
    `CHK(d, 8'hAF, "rmw read gives register")
    ext_en[0][5] <= 1'b0;
    // four registers at their own addresses, others ignored
    for (int i = 0; i < 4; i++) wr(16'(i), {4'(i + 3), 4'hF});
    wr(16'h0004, 8'h00);
    wr(16'h0100, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(16'(i), 1'b1, d);
      `CHK(d, {4'(i + 3), 4'hF}, "port register decode")
    end
    // fourth port turns round as a whole
    mode_ctl <= 8'h20;
    wr(ADDR_PORT_D, 8'hA5);
    `CHK(drv[3], {8'hA5, 8'h00}, "fourth port drives all")
    rd(ADDR_PORT_D, 1'b0, d);
    `CHK(d, 8'hA5, "fourth port output level")
    mode_ctl <= 8'h00;
    repeat (2) @(posedge ref_clk);
    `CHK(drv[3].oe_n, 8'hFF, "fourth port all inputs")
    // third port address lines ignore port writes
    full_addr <= 1'b1;
    alt <= 6'b000010;
    wr(ADDR_PORT_C, 8'h00);
    rd(ADDR_PORT_C, 1'b0, d);
    `CHK(d, 8'h40, "alternate pins undisturbed")
    full_addr <= 1'b0;
    wr(ADDR_PORT_C, 8'hFF);
    // rising flags on pins 0,1 and falling flags on 2,3, masked first
    for (int b = 0; b < 4; b++) pulse_low(0, b);
    `CHK({flags, irq}, 5'b11110, "edge flags masked")
    irq_en <= 4'h4;
    repeat (3) @(posedge ref_clk);
    `CHK(irq, 1'b1, "enabled flag requests")
    clr <= 4'h4;
    @(posedge ref_clk);
    clr <= 4'h0;
    repeat (3) @(posedge ref_clk);
    `CHK({flags, irq}, 5'b10110, "bit clear flag")
    // latch mode: the first port strobe holds second port data
    mode_ctl <= 8'h10;
    ext_en[1] <= 8'hFF;
    ext_val[1] <= 8'h3C;
    pulse_low(0, 0);
    ext_val[1] <= 8'hC3;
    rd(ADDR_PORT_B, 1'b0, d);
    `CHK(d, 8'h3C, "latched second port")
    // counter and transmit duties on the first port outrank a zero written to the register
    mode_ctl <= 8'h05;
    ser_ctl <= 8'h80;
    alt <= 6'b100100;
    wr(ADDR_PORT_A, 8'h00);
    `CHK(drv[0], {8'h50, 8'h00}, "counter and transmit pins")
    // shift clock takes pin 4 ahead of the counter output
    ser_ctl <= 8'hA0;
    alt <= 6'b001100;
    wr(ADDR_PORT_A, 8'h00);
    `CHK(drv[0], {8'h50, 8'h00}, "shift clock outranks counter")
    // input duties keep their pins released whatever the register holds
    mode_ctl <= 8'h0A;
    ser_ctl <= 8'h40;
    wr(ADDR_PORT_A, 8'h00);
    `CHK(drv[0].oe_n, 8'hB0, "input duties released")
    // a second chip reset in mid-run drops the flags raised above and releases the lines
    nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK({flags, irq, drv[0]}, 21'h0FFFF, "second reset")
    rd(ADDR_PORT_C, 1'b1, d);
    `CHK(d, PORT_RESET, "register after second reset")
    test_done();
  end
endmodule
